// ===== rtl/phase_sync_consts.svh
`ifndef PHASE_SYNC_CONSTS_SVH
`define PHASE_SYNC_CONSTS_SVH
// Operation
// RL1 - phase A generator follows sync reference
// RL2 - programmable phase offset to reference
// RL3 - acquisition time before reporting synced
// RL4 - software reads lock status
// RL5 - lock only within setpoint plus range
// RL6 - loop period clamped to capture window
// RL7 - sync sampled on rising edge, 15-5000Hz
// RL8 - speed setting scales tracking rate
// RL9 - synced shown 1s of 3s
// RL10 - strobe on transient start
// RL11 - strobe on output relay change
// RL12 - strobe on any parameter change
// RL13 - transient strobe lasts 190us
// RL14 - relay/param strobe lasts 2ms
// RL15 - phase sync pulse at zero crossing
// RL16 - phase sync width 3us to 100000us
// RL17 - phase sync polarity and 50% mode
// RL18 - software sets setpoint near reference
// RL19 - armed transient starts on trigger edge
// RL20 - strobe not shortened by new events
// RL21 - unlock on lost edges, change visible

// ==========================================
// clock and counter widths
`define CLK_HZ          25000000
`define CLK_PER_US      (`CLK_HZ / 1000000)
`define CLK_PER_MS      (`CLK_HZ / 1000)
`define PW              22
`define DW              27
`define SW              16

// ==========================================
// register map
`define A_CTRL          8'h00
`define A_FSET          8'h04
`define A_RANGE         8'h08
`define A_PHOFF         8'h0c
`define A_SPEED         8'h10
`define A_PSW           8'h14
`define A_STATUS        8'h18
`define A_CMD           8'h1c
`define A_MEAS          8'h20
`define B_LOCKED        0
`define B_LOCK_CHG      1
`define B_TR_WAIT       2
`define B_RUN           0
`define B_STOP          1

// ==========================================
// reset values and timing
`define FSET_DEF_HZ     60
`define RANGE_DEF_HZ    10
`define SPEED_BASE      3'h7
`define LOCK_EDGES      4'h8
`define LOCK_TOL        24'sh000040
`define STROBE_TR_US    190
`define STROBE_LONG_US  2000
`define DISP_PERIOD_MS  3000
`define DISP_ON_MS      1000
`define PSW_MIN_US      22'h000003
`define PSW_MAX_US      22'h0186a0
`define PSW_DEF_US      17'h003e8
`endif

// ===== rtl/phase_sync_pkg.sv
`include "phase_sync_consts.svh"
package phase_sync_pkg;
    typedef enum logic [1:0] {LK_OFF, LK_ACQ, LK_SYNC} lock_t;

    typedef struct packed {
        logic trig_mode;
        logic psync_auto;
        logic psync_pol;
        logic psync_en;
        logic str_param;
        logic str_relay;
        logic str_tran;
        logic sync_en;
    } ctrl_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        ctrl_t            ctrl;
        logic [`PW-1:0]   fset;
        logic [`PW-1:0]   frange;
        logic [`PW-1:0]   phoff;
        logic [2:0]       speed;
        logic [16:0]      psw_us;
        logic [2:0]       sin;
        logic [2:0]       tin;
        logic [`PW-1:0]   ref_cnt;
        logic [`PW-1:0]   meas;
        logic [`PW-1:0]   period;
        logic [`PW-1:0]   phase;
        lock_t            lock;
        logic [3:0]       good;
        logic             lock_chg;
        logic [`DW-1:0]   disp_cnt;
        logic             show_sync;
        logic             show_unsync;
        logic             tr_wait;
        logic             tr_start;
        logic [`SW-1:0]   str_cnt;
        logic             strobe;
        logic [`PW-1:0]   ps_cnt;
        logic             ps_act;
        logic             ps_out;
        logic             zero;
        logic [31:0]      rdata;
    } state_t;
endpackage : phase_sync_pkg

// ===== rtl/phase_sync_io.sv
`timescale 1ns/1ps
`default_nettype none
`include "phase_sync_consts.svh"
module phase_sync_io
    import phase_sync_pkg::*;
#(
    parameter int STROBE_TR_CYC   = `STROBE_TR_US * `CLK_PER_US,
    parameter int STROBE_LONG_CYC = `STROBE_LONG_US * `CLK_PER_US,
    parameter int DISP_PERIOD_CYC = `DISP_PERIOD_MS * `CLK_PER_MS,
    parameter int DISP_ON_CYC     = `DISP_ON_MS * `CLK_PER_MS
) (
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    input  wire bus_req_t        bus,
    output var  logic [31:0]     rdata,
    input  wire logic            sync_in,
    input  wire logic            trig_in,
    input  wire logic            relay_change,
    input  wire logic            param_change,
    output var  logic            strobe_out,
    output var  logic            psync_out,
    output var  logic [`PW-1:0]  wave_phase,
    output var  logic [`PW-1:0]  wave_period,
    output var  logic            phase_a_zero,
    output var  logic            transient_start,
    output var  logic            show_synced,
    output var  logic            show_unsynced
);
    // ==========================================
    // elaboration checks
    if (STROBE_TR_CYC < 1 || STROBE_TR_CYC >= (1 << `SW) ||
        STROBE_LONG_CYC < 1 || STROBE_LONG_CYC >= (1 << `SW))
        $error("strobe width does not fit its counter");
    if (DISP_ON_CYC < 1 || DISP_PERIOD_CYC <= DISP_ON_CYC ||
        DISP_PERIOD_CYC >= (1 << `DW))
        $error("display timing out of range");

    localparam logic [`PW-1:0] FSET_DEF =
        `PW'(`CLK_HZ / `FSET_DEF_HZ);
    localparam logic [`PW-1:0] RANGE_DEF = `PW'(`CLK_HZ / `FSET_DEF_HZ
        - `CLK_HZ / (`FSET_DEF_HZ + `RANGE_DEF_HZ));

    // ==========================================
    // helpers
    function automatic logic [`PW-1:0] clamp(
        input logic [`PW-1:0] v,
        input logic [`PW-1:0] lo,
        input logic [`PW-1:0] hi
    );
        if (v < lo)
            return lo;
        else if (v > hi)
            return hi;
        else
            return v;
    endfunction : clamp

    function automatic state_t rst_state();
        state_t r;
        r = '0;
        r.fset   = FSET_DEF;
        r.period = FSET_DEF;
        r.frange = RANGE_DEF;
        r.psw_us = `PSW_DEF_US;
        r.lock   = LK_OFF;
        return r;
    endfunction : rst_state

    state_t s;
    state_t n;

    logic                   ref_edge;
    logic                   trig_edge;
    logic [`PW-1:0]         lo;
    logic [`PW-1:0]         hi;
    logic [2:0]             shift;
    logic signed [23:0]     diff;
    logic signed [23:0]     err;
    logic signed [23:0]     half;
    logic signed [23:0]     ph;
    logic                   good_edge;
    logic                   ev_tran;
    logic                   ev_long;
    logic [`PW-1:0]         pw_cyc;

    // ==========================================
    // next state
    always_comb begin
        n           = s;
        n.zero      = 1'b0;
        n.tr_start  = 1'b0;
        n.rdata     = '0;
        diff        = '0;
        err         = '0;
        good_edge   = 1'b0;
        // pins pass two flops before use
        n.sin       = {s.sin[1:0], sync_in};
        n.tin       = {s.tin[1:0], trig_in};
        ref_edge    = s.sin[1] & ~s.sin[2]; // RL7
        trig_edge   = s.tin[1] & ~s.tin[2];
        lo          = s.fset - s.frange;
        hi          = s.fset + s.frange;
        shift       = `SPEED_BASE - s.speed; // RL8
        half        = $signed({3'b0, s.period[`PW-1:1]});

        // ---- register writes
        if (bus.wr) begin
            if (bus.addr == `A_CTRL) begin
                n.ctrl = ctrl_t'(bus.wdata[7:0]);
            end else if (bus.addr == `A_FSET) begin
                n.fset = bus.wdata[`PW-1:0];
            end else if (bus.addr == `A_RANGE) begin
                n.frange = bus.wdata[`PW-1:0]; // RL5
            end else if (bus.addr == `A_PHOFF) begin
                n.phoff = bus.wdata[`PW-1:0]; // RL2
            end else if (bus.addr == `A_SPEED) begin
                n.speed = bus.wdata[2:0]; // RL8
            end else if (bus.addr == `A_PSW) begin
                n.psw_us = bus.wdata[16:0]; // RL16
            end else if (bus.addr == `A_STATUS) begin
                if (bus.wdata[`B_LOCK_CHG])
                    n.lock_chg = 1'b0;
            end else if (bus.addr == `A_CMD) begin
                if (bus.wdata[`B_STOP]) begin
                    n.tr_wait = 1'b0;
                end else if (bus.wdata[`B_RUN]) begin
                    if (s.ctrl.trig_mode)
                        n.tr_wait = 1'b1; // RL19
                    else
                        n.tr_start = 1'b1;
                end
            end
        end

        // ---- register reads, data one cycle later
        if (bus.rd) begin
            if (bus.addr == `A_CTRL) begin
                n.rdata[7:0] = s.ctrl;
            end else if (bus.addr == `A_FSET) begin
                n.rdata[`PW-1:0] = s.fset;
            end else if (bus.addr == `A_RANGE) begin
                n.rdata[`PW-1:0] = s.frange;
            end else if (bus.addr == `A_PHOFF) begin
                n.rdata[`PW-1:0] = s.phoff;
            end else if (bus.addr == `A_SPEED) begin
                n.rdata[2:0] = s.speed;
            end else if (bus.addr == `A_PSW) begin
                n.rdata[16:0] = s.psw_us;
            end else if (bus.addr == `A_STATUS) begin
                n.rdata[`B_LOCKED]   = (s.lock == LK_SYNC); // RL4
                n.rdata[`B_LOCK_CHG] = s.lock_chg;
                n.rdata[`B_TR_WAIT]  = s.tr_wait;
            end else if (bus.addr == `A_MEAS) begin
                n.rdata[`PW-1:0] = s.meas;
            end
        end

        // ---- transient trigger
        if (s.tr_wait && s.ctrl.trig_mode && trig_edge) begin
            n.tr_wait  = 1'b0; // RL19
            n.tr_start = 1'b1;
        end

        // ---- phase A generator, one count per clock
        ph = $signed({2'b0, s.phase}) + 24'sd1;
        n.ref_cnt = (&s.ref_cnt) ? s.ref_cnt : s.ref_cnt + 1'b1;
        if (!s.ctrl.sync_en) begin
            n.period = s.fset;
            n.lock   = LK_OFF;
            n.good   = '0;
        end else begin
            if (s.lock == LK_OFF)
                n.lock = LK_ACQ; // RL3
            if (ref_edge) begin
                n.meas    = s.ref_cnt + 1'b1;
                n.ref_cnt = '0;
                if (n.meas >= lo && n.meas <= hi) begin // RL5
                    diff = $signed({2'b0, n.meas})
                         - $signed({2'b0, s.period});
                    n.period = clamp(
                        `PW'(s.period + `PW'(diff >>> shift)),
                        lo, hi); // RL6
                    err = $signed({2'b0, s.phoff})
                        - $signed({2'b0, s.phase}); // RL2
                    if (err > half)
                        err = err - $signed({2'b0, s.period});
                    else if (err < -half)
                        err = err + $signed({2'b0, s.period});
                    ph = ph + (err >>> shift); // RL1
                    good_edge = (err < `LOCK_TOL)
                             && (err > -`LOCK_TOL);
                end
                if (!good_edge) begin
                    n.lock = LK_ACQ; // RL21
                    n.good = '0;
                end else if (s.good == `LOCK_EDGES - 4'h1) begin
                    n.lock = LK_SYNC; // RL3
                end else begin
                    n.good = s.good + 4'h1;
                end
            end else if (s.ref_cnt > hi) begin
                // no edge inside the window: reference lost
                n.lock    = LK_ACQ; // RL21
                n.good    = '0;
                n.ref_cnt = '0;
            end
            n.period = clamp(n.period, lo, hi); // RL6
        end
        if (ph < 0) begin
            ph = ph + $signed({2'b0, n.period});
        end else if (ph >= $signed({2'b0, n.period})) begin
            ph     = ph - $signed({2'b0, n.period});
            // a shrunken period can leave the count past the end
            if (ph >= $signed({2'b0, n.period}))
                ph = '0;
            n.zero = 1'b1; // RL15
        end
        n.phase = ph[`PW-1:0];

        // set beats a same-cycle software clear
        if ((n.lock == LK_SYNC) != (s.lock == LK_SYNC))
            n.lock_chg = 1'b1; // RL21

        // ---- status indicator
        if (s.lock == LK_SYNC) begin
            n.disp_cnt = (s.disp_cnt == `DW'(DISP_PERIOD_CYC - 1))
                       ? '0 : s.disp_cnt + 1'b1;
            n.show_sync = (s.disp_cnt < `DW'(DISP_ON_CYC)); // RL9
        end else begin
            n.disp_cnt  = '0;
            n.show_sync = 1'b0;
        end
        n.show_unsync = s.ctrl.sync_en && (s.lock != LK_SYNC); // RL9

        // ---- function strobe
        ev_tran = s.tr_start && s.ctrl.str_tran; // RL10
        ev_long = (relay_change && s.ctrl.str_relay) // RL11
               || (param_change && s.ctrl.str_param); // RL12
        if (s.strobe) begin
            // events during a pulse are dropped, never restart it
            if (s.str_cnt == '0)
                n.strobe = 1'b0; // RL20
            else
                n.str_cnt = s.str_cnt - 1'b1;
        end else if (ev_long) begin
            n.strobe  = 1'b1;
            n.str_cnt = `SW'(STROBE_LONG_CYC - 1); // RL14
        end else if (ev_tran) begin
            n.strobe  = 1'b1;
            n.str_cnt = `SW'(STROBE_TR_CYC - 1); // RL13
        end

        // ---- phase sync output
        pw_cyc = `PW'(clamp({5'b0, s.psw_us}, `PSW_MIN_US,
                 `PSW_MAX_US) * `CLK_PER_US); // RL16
        if (!s.ctrl.psync_en) begin
            n.ps_act = 1'b0;
        end else if (s.ctrl.psync_auto) begin
            n.ps_act = (n.phase < {1'b0, n.period[`PW-1:1]}); // RL17
        end else if (n.zero) begin
            n.ps_act = 1'b1; // RL15
            n.ps_cnt = pw_cyc - 1'b1;
        end else if (s.ps_act) begin
            if (s.ps_cnt == '0)
                n.ps_act = 1'b0;
            else
                n.ps_cnt = s.ps_cnt - 1'b1;
        end
        n.ps_out = n.ps_act ^ s.ctrl.psync_pol; // RL17
    end

    // ==========================================
    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            s <= rst_state();
        else
            s <= n;
    end

    // ==========================================
    // outputs, all from flops
    assign rdata           = s.rdata;
    assign strobe_out      = s.strobe;
    assign psync_out       = s.ps_out;
    assign wave_phase      = s.phase; // RL1
    assign wave_period     = s.period;
    assign phase_a_zero    = s.zero;
    assign transient_start = s.tr_start;
    assign show_synced     = s.show_sync;
    assign show_unsynced   = s.show_unsync;
endmodule : phase_sync_io
`default_nettype wire

// ===== testbench/sync_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
module sync_ref_model (
    input  wire logic        ref_clk,
    input  wire logic        run,
    input  wire logic [31:0] period,
    output var  logic        sync_pin
);
    // ======================================
    // square reference, rising edge marks 0 deg
    logic [31:0] cnt_r;

    initial begin
        cnt_r = 32'h0;
        sync_pin = 1'b0;
    end

    // period kept within 15..5000 Hz by the bench
    always @(posedge ref_clk) begin
        if (!run || cnt_r >= period - 32'h1) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
        // input load pulls the pin low when absent
        sync_pin <= run && (cnt_r < (period >> 1));
    end
endmodule : sync_ref_model
`default_nettype wire

// ===== testbench/phase_sync_io_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "phase_sync_consts.svh"
module phase_sync_io_monitor
    import phase_sync_pkg::*;
#(
    parameter int STROBE_TR_CYC   = 5,
    parameter int STROBE_LONG_CYC = 9,
    parameter int DISP_ON_CYC     = 4
) (
    input wire logic           ref_clk,
    input wire logic           nrst,
    input wire bus_req_t       bus,
    input wire logic [31:0]    rdata,
    input wire logic           relay_change,
    input wire logic           param_change,
    input wire logic           strobe_out,
    input wire logic [`PW-1:0] wave_phase,
    input wire logic [`PW-1:0] wave_period,
    input wire logic           phase_a_zero,
    input wire logic           transient_start,
    input wire logic           show_synced,
    input wire logic           show_unsynced
);
    // ======================================
    // run lengths; too long for a repetition
    logic [31:0] str_len_r;
    logic [31:0] son_len_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            str_len_r <= 32'h0;
            son_len_r <= 32'h0;
        end else begin
            str_len_r <= strobe_out ? str_len_r + 32'h1 : 32'h0;
            son_len_r <= show_synced ? son_len_r + 32'h1 : 32'h0;
        end
    end

    // ======================================
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_strobe_rise; $rose(strobe_out); endsequence
    sequence s_strobe_hold; strobe_out [*4]; endsequence

    property p_strobe_cause;
        s_strobe_rise |-> $past(relay_change) || $past(param_change)
            || $past(transient_start);
    endproperty
    property p_strobe_width;
        $fell(strobe_out) |-> str_len_r == STROBE_LONG_CYC
            || str_len_r == STROBE_TR_CYC;
    endproperty
    property p_strobe_min; s_strobe_rise |-> s_strobe_hold; endproperty
    property p_phase_range; wave_phase < wave_period; endproperty
    property p_zero_pulse; phase_a_zero |=> !phase_a_zero; endproperty
    property p_tran_pulse; transient_start |=> !transient_start; endproperty
    property p_ind_excl; !(show_synced && show_unsynced); endproperty
    property p_ind_on; son_len_r <= DISP_ON_CYC; endproperty
    property p_rdata_only; rdata != 32'h0 |-> $past(bus.rd); endproperty

    a_strobe_cause: assert property (p_strobe_cause)
        else $error("strobe rose without an event");
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe width wrong");
    a_strobe_min: assert property (p_strobe_min)
        else $error("strobe cut short");
    a_phase_range: assert property (p_phase_range)
        else $error("phase beyond period");
    a_zero_pulse: assert property (p_zero_pulse)
        else $error("zero marker longer than one cycle");
    a_tran_pulse: assert property (p_tran_pulse)
        else $error("transient start longer than one cycle");
    a_ind_excl: assert property (p_ind_excl)
        else $error("both indicator states shown");
    a_ind_on: assert property (p_ind_on)
        else $error("synced shown too long");
    a_rdata_only: assert property (p_rdata_only)
        else $error("read data without a read");
endmodule : phase_sync_io_monitor
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "phase_sync_consts.svh"
module testbench;
    import phase_sync_pkg::*;
    localparam int TR_CYC = 5;
    localparam int LG_CYC = 9;
    localparam int ON_CYC = 4;
    logic           ref_clk = 1'b0;
    logic           nrst    = 1'b0;
    bus_req_t       bus     = '0;
    logic           trig_in = 1'b0;
    logic           relay_change = 1'b0;
    logic           param_change = 1'b0;
    logic           ref_run = 1'b0;
    logic [31:0]    ref_per = 32'h00001388;
    logic [31:0]    rdata;
    logic           sync_in, strobe_out, psync_out, phase_a_zero;
    logic           transient_start, show_synced, show_unsynced;
    logic [`PW-1:0] wave_phase, wave_period;
    int             error_cnt = 0;
    int             checked   = 0;
    int             cyc       = 0;

    phase_sync_io #(.STROBE_TR_CYC(TR_CYC), .STROBE_LONG_CYC(LG_CYC),
        .DISP_PERIOD_CYC(12), .DISP_ON_CYC(ON_CYC)) i_dut (
        .ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
        .sync_in(sync_in), .trig_in(trig_in),
        .relay_change(relay_change), .param_change(param_change),
        .strobe_out(strobe_out), .psync_out(psync_out),
        .wave_phase(wave_phase), .wave_period(wave_period),
        .phase_a_zero(phase_a_zero), .transient_start(transient_start),
        .show_synced(show_synced), .show_unsynced(show_unsynced));
    sync_ref_model i_ref (.ref_clk(ref_clk), .run(ref_run),
        .period(ref_per), .sync_pin(sync_in));

    // ======================================
    // clock, timeout, checks and bus tasks
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 100000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize;
        if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic pulse(int which);
        @(posedge ref_clk);
        if (which == 0) relay_change <= 1'b1;
        else param_change <= 1'b1;
        @(posedge ref_clk);
        relay_change <= 1'b0;
        param_change <= 1'b0;
    endtask : pulse

    // strobe cycles and start pulses in a 20 cycle window
    task automatic win(output int n, output int t);
        n = 0;
        t = 0;
        repeat (20) begin
            @(posedge ref_clk);
            #1 n += (strobe_out === 1'b1);
            t += (transient_start === 1'b1);
        end
    endtask : win

    // ======================================
    // scenarios
    task automatic t_regs;
        logic [31:0] d;
        rd(`A_FSET, d);
        chk("fset_rst", d, 32'h00065b9a);
        @(posedge ref_clk);
        #1 chk("rdata_idle", rdata, 32'h0);
        rd(`A_RANGE, d);
        chk("range_rst", d, 32'h0000e884);
        rd(`A_PSW, d);
        chk("psw_rst", d, 32'h000003e8);
        rd(8'h24, d);
        chk("unmapped", d, 32'h0);
        wr(`A_CTRL, 32'h0000000e);
        rd(`A_CTRL, d);
        chk("ctrl", d, 32'h0000000e);
    endtask : t_regs

    task automatic t_strobe;
        int n, t;
        for (int k = 0; k < 2; k++) begin
            fork pulse(k); win(n, t); join
            chk("strobe_len", n, LG_CYC);
        end
        fork begin pulse(0); pulse(1); end win(n, t); join
        chk("strobe_retrig", n, LG_CYC);
        fork wr(`A_CMD, 32'h1); win(n, t); join
        chk("tran_strobe", n, TR_CYC);
        chk("tran_start", t, 1);
        wr(`A_CTRL, 32'h0);
        fork pulse(0); win(n, t); join
        chk("strobe_off", n, 0);
    endtask : t_strobe

    task automatic t_trig;
        logic [31:0] d;
        int n, t;
        wr(`A_CTRL, 32'h00000082);
        wr(`A_CMD, 32'h1);
        rd(`A_STATUS, d);
        chk("tr_wait", d[2], 1'b1);
        win(n, t);
        chk("no_early", t, 0);
        fork begin @(posedge ref_clk); trig_in <= 1'b1; end win(n, t); join
        chk("trig_start", t, 1);
        chk("trig_strobe", n, TR_CYC);
        @(posedge ref_clk);
        trig_in <= 1'b0;
    endtask : t_trig

    task automatic t_psync;
        int n, len;
        wr(`A_FSET, 32'h00001388);
        wr(`A_PSW, 32'h2); // below minimum, so 3 us
        for (int m = 0; m < 3; m++) begin
            wr(`A_CTRL, m == 0 ? 32'h10 : m == 1 ? 32'h30 : 32'h50);
            len = (m == 2) ? 5000 : 100;
            n = 0;
            repeat (12000) begin
                @(posedge ref_clk);
                #1 if (phase_a_zero === 1'b1) break;
            end
            repeat (len) begin
                n += (psync_out === (m != 1));
                @(posedge ref_clk);
                #1;
            end
            chk("psync", n, m == 2 ? 2500 : 75);
        end
    endtask : t_psync

    task automatic t_lock;
        logic [31:0] d;
        int n;
        wr(`A_CTRL, 32'h0);
        wr(`A_RANGE, 32'h000001f4);
        wr(`A_PHOFF, 32'h00000064);
        // full gain: slower settings take too many edges to lock
        wr(`A_SPEED, 32'h7);
        ref_run <= 1'b1; // setpoint already at reference
        wr(`A_CTRL, 32'h1);
        repeat (100) @(posedge ref_clk);
        #1 chk("unsynced", show_unsynced, 1'b1);
        rd(`A_STATUS, d);
        chk("not_yet", d[0], 1'b0);
        repeat (80) begin
            if (d[0] === 1'b1) break;
            repeat (1000) @(posedge ref_clk);
            rd(`A_STATUS, d);
        end
        chk("locked", d[1:0], 2'b11);
        wr(`A_STATUS, 32'h2);
        rd(`A_STATUS, d);
        chk("chg_clr", d[1:0], 2'b01);
        n = 0;
        repeat (12) begin
            @(posedge ref_clk);
            #1 n += (show_synced === 1'b1);
        end
        chk("synced_share", n, ON_CYC);
        // pin edge is seen three clocks later, phase then at offset+1
        @(posedge sync_in);
        repeat (3) @(posedge ref_clk);
        #1 chk("ref_phase", wave_phase, 32'h00000065);
        chk("win_lock", wave_period >= 4500 && wave_period <= 5500, 1);
        ref_per <= 32'h00001b58; // drifts out of the window
        repeat (8000) @(posedge ref_clk);
        rd(`A_STATUS, d);
        chk("lost", d[1:0], 2'b10);
        chk("win_drift", wave_period <= 5500 && wave_period >= 4500, 1);
        ref_run <= 1'b0;
        repeat (6000) @(posedge ref_clk);
        #1 chk("absent", show_unsynced, 1'b1);
        chk("win_gone", wave_period <= 5500 && wave_period >= 4500, 1);
    endtask : t_lock

    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_strobe();
        t_trig();
        t_psync();
        t_lock();
        summarize();
    end
endmodule : testbench

bind phase_sync_io phase_sync_io_monitor #(
    .STROBE_TR_CYC(STROBE_TR_CYC), .STROBE_LONG_CYC(STROBE_LONG_CYC),
    .DISP_ON_CYC(DISP_ON_CYC)) i_mon (
    .ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .relay_change(relay_change), .param_change(param_change),
    .strobe_out(strobe_out), .wave_phase(wave_phase),
    .wave_period(wave_period), .phase_a_zero(phase_a_zero),
    .transient_start(transient_start), .show_synced(show_synced),
    .show_unsynced(show_unsynced));
`default_nettype wire
